// >>> hdl/ioxp_pkg.sv
// Shared constants for the I2C octal I/O expander and its bus controller.
package ioxp_pkg;
   localparam int       IOXP_WIDTH        = 8;
   localparam logic [6:0] IOXP_ADDR_BASE  = 7'h20;
   localparam logic [1:0] IOXP_REG_INPUT  = 2'h0;
   localparam logic [1:0] IOXP_REG_OUTPUT = 2'h1;
   localparam logic [1:0] IOXP_REG_INVERT = 2'h2;
   localparam logic [1:0] IOXP_REG_DIR    = 2'h3;
   localparam logic [7:0] IOXP_RST_OUTPUT = 8'hff;
   localparam logic [7:0] IOXP_RST_INVERT = 8'h00;
   localparam logic [7:0] IOXP_RST_DIR    = 8'hff;
   localparam logic [7:0] IOXP_RST_PTR    = 8'h00;
   localparam int       IOXP_DIR_BIT      = 0;
   localparam logic     IOXP_DIR_WRITE    = 1'b0;
   localparam logic     IOXP_DIR_READ     = 1'b1;
   // Bus clock rate: 125 MHz system clock, 400 kHz SCL.
   localparam int       IOXP_CLK_MHZ      = 125;
   localparam int       IOXP_SCL_KHZ      = 400;
   localparam int       IOXP_QTR_CYC      =
      (IOXP_CLK_MHZ * 1000) / (IOXP_SCL_KHZ * 4);
endpackage

// >>> hdl/ioxp_bus_if.sv
// Two-wire bus between the expander and its controller.
`timescale 1ns/1ps
interface ioxp_bus_if;
   logic scl_oe_n;
   logic sda_ctl_oe_n;
   logic sda_dev_oe_n;
   logic scl;
   logic sda;
   // Open drain wires with pull-ups: low when any end enables its driver.
   assign scl = scl_oe_n;
   assign sda = sda_ctl_oe_n & sda_dev_oe_n;
   modport device
   (
      input  scl,
      input  sda,
      output sda_dev_oe_n
   );
   modport controller
   (
      input  scl,
      input  sda,
      output scl_oe_n,
      output sda_ctl_oe_n
   );
endinterface

// >>> hdl/ioxp_ctl.sv
// Bus controller end: runs one write or read transfer per request.
`timescale 1ns/1ps
module ioxp_ctl
   import ioxp_pkg::*;
#(
   parameter int QTR = IOXP_QTR_CYC
)
(
   input  wire logic                clk,
   input  wire logic                sys_rst,
   ioxp_bus_if.controller           bus,
   input  wire logic                req,
   input  wire logic                req_rd,
   input  wire logic                req_ptr_only,
   input  wire logic [6:0]          req_addr,
   input  wire logic [7:0]          req_ptr,
   input  wire logic [7:0]          req_data,
   output logic                     busy_ff,
   output logic                     done_ff,
   output logic                     nack_ff,
   output logic [7:0]               rd_data_ff
);
   typedef enum logic [2:0] {ST_IDLE, ST_START, ST_BIT, ST_ACK, ST_RSTART,
                             ST_STOP} ioxp_cst_e;
   ioxp_cst_e   st_ff;
   logic [15:0] qcnt_ff;
   logic [1:0]  ph_ff;
   logic [2:0]  bit_ff;
   logic [1:0]  byte_ff;
   logic [7:0]  sh_ff;
   logic        rd_ff;
   logic        ptr_only_ff;
   logic [6:0]  addr_ff;
   logic [7:0]  ptr_ff;
   logic [7:0]  wdat_ff;
   logic        scl_oe_n_ff;
   logic        sda_oe_n_ff;
   logic        tick;

   assign tick             = (qcnt_ff == 16'(QTR - 1));
   assign bus.scl_oe_n     = scl_oe_n_ff;
   assign bus.sda_ctl_oe_n = sda_oe_n_ff;

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         qcnt_ff <= 16'h0000;
      else if (st_ff == ST_IDLE || tick)
         qcnt_ff <= 16'h0000;
      else
         qcnt_ff <= qcnt_ff + 16'h0001;
   end

   ////////////////////////////////////////////////////////////////////////
   // Byte 0 is the address, then pointer and data for writes; a read
   // restarts after the pointer with byte 2 as the read address, and
   // byte 3 is always the returned data, so the data line is released for it.
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st_ff       <= ST_IDLE;
         ph_ff       <= 2'h0;
         bit_ff      <= 3'h0;
         byte_ff     <= 2'h0;
         sh_ff       <= 8'h00;
         rd_ff       <= 1'b0;
         ptr_only_ff <= 1'b0;
         addr_ff     <= 7'h00;
         ptr_ff      <= 8'h00;
         wdat_ff     <= 8'h00;
         scl_oe_n_ff <= 1'b1;
         sda_oe_n_ff <= 1'b1;
         busy_ff     <= 1'b0;
         done_ff     <= 1'b0;
         nack_ff     <= 1'b0;
         rd_data_ff  <= 8'h00;
      end
      else
      begin
         done_ff <= 1'b0;
         unique case (st_ff)
            ST_IDLE:
               if (req)
               begin
                  rd_ff       <= req_rd;
                  ptr_only_ff <= req_ptr_only;
                  addr_ff     <= req_addr;
                  ptr_ff      <= req_ptr;
                  wdat_ff     <= req_data;
                  busy_ff     <= 1'b1;
                  nack_ff     <= 1'b0;
                  byte_ff     <= 2'h0;
                  ph_ff       <= 2'h0;
                  st_ff       <= ST_START;
               end
            ST_START:
               if (tick)
               begin
                  // START: data falls while clock is high.
                  ph_ff <= ph_ff + 2'h1;
                  if (ph_ff == 2'h1)
                     sda_oe_n_ff <= 1'b0;
                  if (ph_ff == 2'h2)
                     scl_oe_n_ff <= 1'b0;
                  if (ph_ff == 2'h3)
                  begin
                     // Address-only read skips the pointer write.
                     sh_ff  <= (rd_ff && byte_ff == 2'h0 && !ptr_only_ff) ?
                               {addr_ff, IOXP_DIR_WRITE} :
                               (byte_ff == 2'h0) ?
                               {addr_ff, rd_ff} : {addr_ff, IOXP_DIR_READ};
                     bit_ff <= 3'h7;
                     ph_ff  <= 2'h0;
                     st_ff  <= ST_BIT;
                  end
               end
            ST_BIT:
               if (tick)
               begin
                  ph_ff <= ph_ff + 2'h1;
                  unique case (ph_ff)
                     2'h0: sda_oe_n_ff <= (rd_ff && byte_ff == 2'h3) |
                                          sh_ff[7];
                     2'h1: scl_oe_n_ff <= 1'b1;
                     2'h2: sh_ff <= {sh_ff[6:0], bus.sda};
                     2'h3:
                     begin
                        scl_oe_n_ff <= 1'b0;
                        if (bit_ff == 3'h0)
                           st_ff <= ST_ACK;
                        bit_ff <= bit_ff - 3'h1;
                     end
                  endcase
               end
            ST_ACK:
               if (tick)
               begin
                  ph_ff <= ph_ff + 2'h1;
                  unique case (ph_ff)
                     // one byte is read, so it is not acknowledged.
                     2'h0: sda_oe_n_ff <= 1'b1;
                     2'h1: scl_oe_n_ff <= 1'b1;
                     2'h2:
                     begin
                        if (rd_ff && byte_ff == 2'h3)
                           rd_data_ff <= sh_ff;
                        else if (bus.sda)
                           nack_ff <= 1'b1;
                     end
                     2'h3:
                     begin
                        scl_oe_n_ff <= 1'b0;
                        bit_ff      <= 3'h7;
                        byte_ff     <= byte_ff + 2'h1;
                        if (nack_ff || (rd_ff && byte_ff == 2'h3) ||
                            (!rd_ff && byte_ff == 2'h2))
                           st_ff <= ST_STOP;
                        else if (rd_ff && byte_ff == 2'h0 && ptr_only_ff)
                        begin
                           byte_ff <= 2'h3;
                           sh_ff   <= 8'hff;
                           st_ff   <= ST_BIT;
                        end
                        else if (rd_ff && byte_ff == 2'h1)
                           st_ff <= ST_RSTART;
                        else
                        begin
                           sh_ff <= (byte_ff == 2'h0) ? ptr_ff : wdat_ff;
                           st_ff <= ST_BIT;
                        end
                     end
                  endcase
               end
            ST_RSTART:
               if (tick)
               begin
                  sda_oe_n_ff <= 1'b1;
                  scl_oe_n_ff <= 1'b1;
                  ph_ff       <= 2'h1;
                  st_ff       <= ST_START;
               end
            ST_STOP:
               if (tick)
               begin
                  ph_ff <= ph_ff + 2'h1;
                  unique case (ph_ff)
                     2'h0: sda_oe_n_ff <= 1'b0;
                     2'h1: scl_oe_n_ff <= 1'b1;
                     2'h2: sda_oe_n_ff <= 1'b1;
                     2'h3:
                     begin
                        busy_ff <= 1'b0;
                        done_ff <= 1'b1;
                        st_ff   <= ST_IDLE;
                     end
                  endcase
               end
            default: st_ff <= ST_IDLE;
         endcase
      end
   end
endmodule

// >>> hdl/ioxp_dev.sv
// Expander end: two-wire target, four byte registers, pin and interrupt.
`timescale 1ns/1ps
// Function
// - Write: start, address+0, pointer, data, stop
// - Acknowledge own address and pointer byte
// - Read: pointer write, restart, address+1
// - Controller acks more, nacks last, stops
// - Read without prior pointer write uses current pointer
// - Address 0x20 strap low, 0x21 high
// - Address byte LSB selects read or write
// - First written byte becomes register pointer
// - Low two pointer bits select the register
// - Input register shows pin levels, ignores writes
// - Controller sets pointer 0 before input reads
// - Input data captured at latest acknowledge
// - Output latch drives outputs only, resets ones
// - Invert bit flips reported input level
// - Direction one is input, zero output
// - Input edge raises open-drain interrupt
// - Interrupt clears on return or input read
// - Outputs and foreign transfers never interrupt
// - Reset pin low holds all defaults
module ioxp_dev
   import ioxp_pkg::*;
#(
   parameter int W = IOXP_WIDTH
)
(
   input  wire logic                clk,
   input  wire logic                sys_rst,
   ioxp_bus_if.device               bus,
   input  wire logic                reset_n,
   input  wire logic                addr_strap,
   input  wire logic [W-1:0]        pin_in,
   output logic      [W-1:0]        pin_out_ff,
   output logic      [W-1:0]        pin_oe_n_ff,
   output logic                     irq_oe_n_ff
);
   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_WBYTE, ST_RBYTE,
                             ST_RACK} ioxp_dst_e;
   ioxp_dst_e   st_ff;
   logic        scl_ff;
   logic        sda_ff;
   logic [2:0]  cnt_ff;
   logic [7:0]  sh_ff;
   logic        rd_ff;
   logic        ptr_seen_ff;
   logic        sda_oe_n_ff;
   logic [7:0]  ptr_ff;
   logic [W-1:0] out_ff;
   logic [W-1:0] inv_ff;
   logic [W-1:0] dir_ff;
   logic [W-1:0] snap_ff;
   logic        strap_ff;
   logic        rst_pin_n;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_c;
   logic        stop_c;
   logic [W-1:0] in_view;
   logic        in_read_ack;
   logic        full_ff;
   logic [7:0]  rd_byte;

   // Pin reset shares the asynchronous path of the system reset.
   assign rst_pin_n = ~sys_rst & reset_n;
   assign scl_rise  = bus.scl & ~scl_ff;
   assign scl_fall  = ~bus.scl & scl_ff;
   assign start_c   = scl_ff & bus.scl & sda_ff & ~bus.sda;
   assign stop_c    = scl_ff & bus.scl & ~sda_ff & bus.sda;
   assign in_view   = pin_in ^ inv_ff;
   assign bus.sda_dev_oe_n = sda_oe_n_ff;
   assign in_read_ack = (st_ff == ST_RACK) && scl_rise &&
                        ptr_ff[1:0] == IOXP_REG_INPUT;

   function automatic logic [7:0] reg_read(input logic [1:0] sel);
      unique case (sel)
         IOXP_REG_INPUT:  reg_read = 8'(in_view);
         IOXP_REG_OUTPUT: reg_read = 8'(out_ff);
         IOXP_REG_INVERT: reg_read = 8'(inv_ff);
         IOXP_REG_DIR:    reg_read = 8'(dir_ff);
      endcase
   endfunction

   always_comb
      rd_byte = reg_read(ptr_ff[1:0]);

   always_ff @(posedge clk or negedge rst_pin_n)
   begin
      if (!rst_pin_n)
      begin
         scl_ff <= 1'b1;
         sda_ff <= 1'b1;
      end
      else
      begin
         scl_ff <= bus.scl;
         sda_ff <= bus.sda;
      end
   end

   // The strap is sampled by an unreset clocked process on every clock, also during reset.
   always_ff @(posedge clk)
      strap_ff <= addr_strap;

   ////////////////////////////////////////////////////////////////////////
   // Bus state machine; the data line only changes while the clock is low.
   always_ff @(posedge clk or negedge rst_pin_n)
   begin
      if (!rst_pin_n)
      begin
         st_ff       <= ST_IDLE;
         cnt_ff      <= 3'h0;
         full_ff     <= 1'b0;
         sh_ff       <= 8'h00;
         rd_ff       <= 1'b0;
         ptr_seen_ff <= 1'b0;
         sda_oe_n_ff <= 1'b1;
         ptr_ff      <= IOXP_RST_PTR;
         out_ff      <= IOXP_RST_OUTPUT;
         inv_ff      <= IOXP_RST_INVERT;
         dir_ff      <= IOXP_RST_DIR;
      end
      else if (stop_c)
      begin
         st_ff       <= ST_IDLE;
         sda_oe_n_ff <= 1'b1;
      end
      else if (start_c)
      begin
         st_ff       <= ST_ADDR;
         cnt_ff      <= 3'h7;
         full_ff     <= 1'b0;
         sda_oe_n_ff <= 1'b1;
      end
      else
      begin
         unique case (st_ff)
            ST_IDLE: ;
            ST_ADDR, ST_WBYTE:
               if (scl_rise)
               begin
                  sh_ff   <= {sh_ff[6:0], bus.sda};
                  cnt_ff  <= cnt_ff - 3'h1;
                  full_ff <= (cnt_ff == 3'h0);
               end
               // The clock fall that closes a start carries no bit, so a
               // byte is only decided once eight rises have been seen.
               else if (scl_fall && full_ff)
               begin
                  full_ff <= 1'b0;
                  if (st_ff == ST_ADDR)
                  begin
                     if (sh_ff[7:1] == (IOXP_ADDR_BASE | 7'(strap_ff)))
                     begin
                        rd_ff       <= sh_ff[IOXP_DIR_BIT];
                        sda_oe_n_ff <= 1'b0;
                        st_ff       <= ST_ACK;
                     end
                     else
                        st_ff <= ST_IDLE;
                     ptr_seen_ff <= 1'b0;
                  end
                  else
                  begin
                     sda_oe_n_ff <= 1'b0;
                     st_ff       <= ST_ACK;
                     if (!ptr_seen_ff)
                     begin
                        ptr_ff      <= sh_ff;
                        ptr_seen_ff <= 1'b1;
                     end
                     else
                        unique case (ptr_ff[1:0])
                           IOXP_REG_INPUT:  ;
                           IOXP_REG_OUTPUT: out_ff <= W'(sh_ff);
                           IOXP_REG_INVERT: inv_ff <= W'(sh_ff);
                           IOXP_REG_DIR:    dir_ff <= W'(sh_ff);
                        endcase
                  end
               end
            ST_ACK:
               if (scl_fall)
               begin
                  cnt_ff <= 3'h7;
                  // A read transfer only sends data; none of its bytes is
                  // ever taken as a pointer.
                  if (rd_ff)
                  begin
                     // input levels are sampled at this edge.
                     sh_ff       <= {rd_byte[6:0], 1'b0};
                     sda_oe_n_ff <= rd_byte[7];
                     st_ff       <= ST_RBYTE;
                  end
                  else
                  begin
                     sda_oe_n_ff <= 1'b1;
                     st_ff       <= ST_WBYTE;
                  end
               end
            ST_RBYTE:
               if (scl_fall)
               begin
                  if (cnt_ff == 3'h0)
                  begin
                     sda_oe_n_ff <= 1'b1;
                     st_ff       <= ST_RACK;
                  end
                  else
                  begin
                     sda_oe_n_ff <= sh_ff[7];
                     sh_ff       <= {sh_ff[6:0], 1'b0};
                     cnt_ff      <= cnt_ff - 3'h1;
                  end
               end
            ST_RACK:
               if (scl_rise)
                  // a not-acknowledge ends the byte stream.
                  st_ff <= bus.sda ? ST_IDLE : ST_ACK;
            default: st_ff <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pins and interrupt. The snapshot is the raw pin value at the ack of the last input read.
   always_ff @(posedge clk or negedge rst_pin_n)
   begin
      if (!rst_pin_n)
      begin
         pin_out_ff  <= '1;
         pin_oe_n_ff <= '1;
      end
      else
      begin
         pin_out_ff  <= out_ff;
         pin_oe_n_ff <= dir_ff;
      end
   end

   always_ff @(posedge clk or negedge rst_pin_n)
   begin
      if (!rst_pin_n)
      begin
         snap_ff     <= '0;
         irq_oe_n_ff <= 1'b1;
      end
      else
      begin
         // a read of the input register resets the reference.
         if (in_read_ack)
            snap_ff <= pin_in;
         // Only input pins that differ from the reference count.
         irq_oe_n_ff <= ~(|((pin_in ^ snap_ff) & dir_ff)) |
                        in_read_ack;
      end
   end
endmodule

// >>> testbench/ioxp_sva.sv
// Bus checker for the expander's two-wire link.
`timescale 1ns/1ps
module ioxp_sva
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic scl_oe_n,
   input wire logic sda_ctl_oe_n,
   input wire logic sda_dev_oe_n,
   input wire logic scl,
   input wire logic sda
);
   logic       scl_ff;
   logic       sda_ff;
   logic       rd_ff;
   logic       ackd_ff;
   logic [5:0] cnt_ff;
   logic       rise;
   logic       start;
   // Bit slots count clock rises since the latest start or restart.
   assign rise  = scl & ~scl_ff;
   assign start = scl & scl_ff & sda_ff & ~sda;
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         scl_ff <= 1'b1;
         sda_ff <= 1'b1;
      end
      else
      begin
         scl_ff <= scl;
         sda_ff <= sda;
      end
   end
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         cnt_ff <= 6'h00;
      else if (start)
         cnt_ff <= 6'h00;
      else if (rise && cnt_ff != 6'h3f)
         cnt_ff <= cnt_ff + 6'h01;
   end
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rd_ff   <= 1'b0;
         ackd_ff <= 1'b0;
      end
      else if (rise && cnt_ff == 6'h07)
         rd_ff <= sda;
      else if (rise && cnt_ff == 6'h08)
         ackd_ff <= ~sda_dev_oe_n;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   addr_quiet_a: assert property (rise && cnt_ff < 6'h08
      |-> sda_dev_oe_n)
      else $error("device drove an address bit");
   wr_slot_a: assert property (rise && !rd_ff && cnt_ff > 6'h08
      && cnt_ff % 9 != 8 |-> sda_dev_oe_n)
      else $error("device drove a written data bit");
   ptr_ack_a: assert property (rise && !rd_ff && ackd_ff
      && (cnt_ff == 6'h11 || cnt_ff == 6'h1a) |-> !sda_dev_oe_n)
      else $error("device missed pointer or data ack");
   rd_slot_a: assert property (rise && rd_ff && cnt_ff > 6'h08
      && cnt_ff % 9 == 8 |-> sda_dev_oe_n)
      else $error("device drove the controller ack slot");
   ctl_release_a: assert property (rise && rd_ff && cnt_ff > 6'h08
      && cnt_ff < 6'h11 |-> sda_ctl_oe_n)
      else $error("controller held data line in read");
   last_nack_a: assert property (rise && rd_ff && cnt_ff == 6'h11
      |-> sda)
      else $error("last read byte was acknowledged");
   sda_stable_a: assert property (scl && scl_ff
      |-> $stable(sda_dev_oe_n))
      else $error("device changed data while clock high");
   start_free_a: assert property (start |-> sda_dev_oe_n)
      else $error("device held data line at start");
   rst_idle_a: assert property ($fell(sys_rst) |-> sda_dev_oe_n
      && sda_ctl_oe_n && scl_oe_n)
      else $error("bus not released out of reset");
   start_c: cover property (start);
   rd_byte_c: cover property (rise && rd_ff && cnt_ff == 6'h10);
   ack_c: cover property (rise && cnt_ff == 6'h08 && !sda_dev_oe_n);
   nack_c: cover property (rise && cnt_ff == 6'h08 && sda);
endmodule

// >>> testbench/i2c_octal_io_expander_tb.sv
// Self-checking bench: controller end talks to the expander end.
`timescale 1ns/1ps
module i2c_octal_io_expander_tb;
   import ioxp_pkg::*;
   logic        clk;
   logic        sys_rst;
   logic        reset_n;
   logic        addr_strap;
   logic [7:0]  pin_in;
   logic [7:0]  pin_out_ff;
   logic [7:0]  pin_oe_n_ff;
   logic        irq_oe_n_ff;
   logic        req;
   logic        req_rd;
   logic        req_ptr_only;
   logic [6:0]  req_addr;
   logic [7:0]  req_ptr;
   logic [7:0]  req_data;
   logic        busy_ff;
   logic        done_ff;
   logic        nack_ff;
   logic [7:0]  rd_data_ff;
   logic [31:0] seed;
   int          n_mismatch;
   int          samples_checked;
   int          m_out;
   int          m_inv;
   int          m_dir;
   int          m_ptr;
   ioxp_bus_if ioxp_bus_if_i ();
   ioxp_ctl #(.QTR(4)) ioxp_ctl_i
   (
      .clk          (clk),
      .sys_rst      (sys_rst),
      .bus          (ioxp_bus_if_i),
      .req          (req),
      .req_rd       (req_rd),
      .req_ptr_only (req_ptr_only),
      .req_addr     (req_addr),
      .req_ptr      (req_ptr),
      .req_data     (req_data),
      .busy_ff      (busy_ff),
      .done_ff      (done_ff),
      .nack_ff      (nack_ff),
      .rd_data_ff   (rd_data_ff)
   );
   ioxp_dev ioxp_dev_i
   (
      .clk         (clk),
      .sys_rst     (sys_rst),
      .bus         (ioxp_bus_if_i),
      .reset_n     (reset_n),
      .addr_strap  (addr_strap),
      .pin_in      (pin_in),
      .pin_out_ff  (pin_out_ff),
      .pin_oe_n_ff (pin_oe_n_ff),
      .irq_oe_n_ff (irq_oe_n_ff)
   );
   ioxp_sva ioxp_sva_i
   (
      .clk          (clk),
      .sys_rst      (sys_rst),
      .scl_oe_n     (ioxp_bus_if_i.scl_oe_n),
      .sda_ctl_oe_n (ioxp_bus_if_i.sda_ctl_oe_n),
      .sda_dev_oe_n (ioxp_bus_if_i.sda_dev_oe_n),
      .scl          (ioxp_bus_if_i.scl),
      .sda          (ioxp_bus_if_i.sda)
   );
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   task automatic chk8(input logic [7:0] got, input int exp);
      samples_checked++;
      if (got !== exp[7:0])
      begin
         n_mismatch++;
         $display("[FAIL] %0t byte %h expected %h", $time, got, exp[7:0]);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
      end
   endtask
   task automatic mreset();
      m_out = IOXP_RST_OUTPUT;
      m_inv = IOXP_RST_INVERT;
      m_dir = IOXP_RST_DIR;
      m_ptr = IOXP_RST_PTR;
   endtask
   // One whole transfer; the model follows only when the address matched.
   task automatic xfer(input logic rd, input logic po, input logic [6:0] a,
                       input logic [7:0] p, input logic [7:0] d);
      int   n;
      logic ack;
      ack = (a === (IOXP_ADDR_BASE | {6'h00, addr_strap}));
      @(posedge clk);
      #1;
      {req, req_rd, req_ptr_only, req_addr, req_ptr, req_data} =
         {1'b1, rd, po, a, p, d};
      @(posedge clk);
      #1;
      req = 1'b0;
      chk1(busy_ff, 1'b1);
      n = 0;
      while (done_ff !== 1'b1 && n < 3000)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      chk1(done_ff, 1'b1);
      chk1(busy_ff, 1'b0);
      chk1(nack_ff, ~ack);
      if (ack && !po)
         m_ptr = p;
      if (ack && !rd)
         case (m_ptr[1:0])
            IOXP_REG_OUTPUT: m_out = d;
            IOXP_REG_INVERT: m_inv = d;
            IOXP_REG_DIR:    m_dir = d;
            default:         ;
         endcase
      if (ack && rd)
         chk8(rd_data_ff, m_ptr[1:0] == 0 ? pin_in ^ m_inv[7:0]
            : m_ptr[1:0] == 1 ? m_out : m_ptr[1:0] == 2 ? m_inv : m_dir);
      chk8(pin_out_ff, m_out);
      chk8(pin_oe_n_ff, m_dir);
   endtask
   task automatic irq_chk(input logic [7:0] p, input logic e);
      @(posedge clk);
      #1;
      pin_in = p;
      repeat (6) @(posedge clk);
      #1;
      chk1(irq_oe_n_ff, e);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial
   begin
      repeat (90000) @(posedge clk);
      n_mismatch++;
      complete_run();
   end
   initial
   begin
      {sys_rst, reset_n, addr_strap, pin_in, req} = {3'b110, 8'h00, 1'b0};
      {req_rd, req_ptr_only, req_addr, req_ptr, req_data} = 25'h0;
      {seed, n_mismatch, samples_checked} = {32'h46, 64'h0};
      mreset();
      repeat (12) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      for (int r = 1; r < 4; r++)
         xfer(1'b1, 1'b0, 7'h20, r[7:0], 8'h00);
      for (int k = 0; k < 12; k++)
      begin
         seed = xs(seed);
         pin_in = seed[23:16];
         // Upper pointer bits are random and must not change the decode.
         xfer(1'b0, 1'b0, 7'h20, {seed[7:2], k[1:0]}, seed[15:8]);
         xfer(1'b1, 1'b0, 7'h20, {seed[31:26], k[1:0]}, 8'h00);
         xfer(1'b1, 1'b1, 7'h20, 8'h00, 8'h00);
      end
      for (int k = 0; k < 6; k++)
      begin
         addr_strap = (k > 2);
         seed = xs(seed);
         xfer(1'b0, 1'b0, IOXP_ADDR_BASE + 7'(k % 3), 8'h01,
              seed[7:0]);
      end
      addr_strap = 1'b0;
      xfer(1'b0, 1'b0, 7'h20, 8'h02, 8'h00);
      xfer(1'b0, 1'b0, 7'h20, 8'h03, 8'h0f);
      pin_in = 8'h05;
      xfer(1'b1, 1'b0, 7'h20, 8'h00, 8'h00);
      irq_chk(8'h45, 1'b1);
      irq_chk(8'h47, 1'b0);
      irq_chk(8'h45, 1'b1);
      irq_chk(8'h44, 1'b0);
      xfer(1'b0, 1'b0, 7'h22, 8'h01, 8'h00);
      chk1(irq_oe_n_ff, 1'b0);
      xfer(1'b1, 1'b1, 7'h20, 8'h00, 8'h00);
      chk1(irq_oe_n_ff, 1'b1);
      xfer(1'b0, 1'b0, 7'h20, 8'h01, 8'h5a);
      reset_n = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk8(pin_out_ff, IOXP_RST_OUTPUT);
      chk8(pin_oe_n_ff, IOXP_RST_DIR);
      reset_n = 1'b1;
      mreset();
      xfer(1'b1, 1'b1, 7'h20, 8'h00, 8'h00);
      for (int r = 1; r < 4; r++)
         xfer(1'b1, 1'b0, 7'h20, r[7:0], 8'h00);
      complete_run();
   end
endmodule
